// file: logic/fmvp_cfg.svh
`ifndef FMVP_CFG_SVH
`define FMVP_CFG_SVH
// Instrument parameter change offsets.
`define FMVP_I_LFOENA   8'h0A
`define FMVP_I_GLIDE    8'h0B
`define FMVP_I_BEND     8'h0C
`define FMVP_I_PLAY     8'h0D
`define FMVP_I_VIBSRC   8'h0E
// Voice parameter change offsets.
`define FMVP_V_RATE     8'h08
`define FMVP_V_AMD      8'h09
`define FMVP_V_PMD      8'h0A
`define FMVP_V_OPEN     8'h0B
`define FMVP_V_ALGFB    8'h0C
`define FMVP_V_SENS     8'h0D
`define FMVP_V_WAVE     8'h0E
`define FMVP_V_XPOSE    8'h0F
`define FMVP_V_ROLE     8'h15
// Register bus word addresses.
`define FMVP_A_INST     4'h0
`define FMVP_A_VOICE    4'h1
`define FMVP_A_CTRL     4'h2
`define FMVP_A_NOTE     4'h3
`define FMVP_A_STAT     4'h4
`define FMVP_A_MOD      4'h5
`define FMVP_A_SHIFT    4'h6
// Field limits and positions.
`define FMVP_GLIDE_MAX  7'h7F
`define FMVP_BEND_MAX   4'hC
`define FMVP_VIB_MAX    3'h4
`define FMVP_OPEN_LSB   3
`define FMVP_NOTE_TOP   8'h7F
`define FMVP_OCTAVE     8'h0C
`define FMVP_DEAD       32'hDEAD_BEEF
`endif

// file: logic/fmvp_pkg.sv
package fmvp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK} fmvp_state_e;
  typedef struct packed {
    fmvp_state_e bus;
    logic [31:0] rdata;
    // Active instrument function set and the stored copy for voice-follow.
    logic [6:0]  glide;
    logic [3:0]  bend;
    logic        single;
    logic [2:0]  vibSrc;
    logic        lfoOff;
    logic [6:0]  glideSv;
    logic [3:0]  bendSv;
    logic        singleSv;
    logic [2:0]  vibSrcSv;
    logic        follow;
    // Voice settings.
    logic [7:0]  xpose;
    logic [2:0]  alg;
    logic [2:0]  fb;
    logic [3:0]  opOn;
    logic [3:0]  role;
    logic [1:0]  amplitude_mod_sensitivity;
    logic [2:0]  pitch_mod_sensitivity;
    logic        lfoSync;
    logic        lfoLoad;
    logic [1:0]  wave;
    logic [7:0]  rate;
    logic [6:0]  amplitude_mod_depth;
    logic [6:0]  pitch_mod_depth;
    logic [1:0]  waveAct;
    logic [7:0]  rateAct;
    logic [6:0]  amdAct;
    logic [6:0]  pmdAct;
    // Single-line note memory, newest first.
    logic [7:0]  held0;
    logic [7:0]  held1;
    logic [7:0]  held2;
    logic [1:0]  heldCnt;
    logic [7:0]  note;
    logic        keyOn;
    logic        attack;
    logic        slide;
    logic        lfoRestart;
  } fmvp_state_s;
endpackage

// file: logic/fmvp_voice_ctrl.sv
`include "fmvp_cfg.svh"
module fmvp_voice_ctrl
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic      [7:0]  playNote,
  output logic             keyOn,
  output logic             attackStart,
  output logic             glideActive,
  output logic             lfoRestart,
  output logic      [3:0]  opEnable,
  output logic             ampModOn,
  output logic             pitchModOn
);
  fmvp_pkg::fmvp_state_s st_r;
  fmvp_pkg::fmvp_state_s st_nxt;
  logic [3:0] wordAddr;
  logic       req;
  assign wordAddr = address[5:2];
  assign req      = read | write;

  // Folds a shifted note into 0..127 by whole octaves.
  // Eleven octave steps cover the worst case of either sign, so the loops stay bounded.
  function automatic logic [7:0] foldNote(input logic [8:0] n);
    logic signed [9:0] v;
    v = {n[8], n};
    for (int i = 0; i < 11; i++)
      if (v > $signed({2'b00, `FMVP_NOTE_TOP}))
        v = v - $signed({2'b00, `FMVP_OCTAVE});
    for (int i = 0; i < 11; i++)
      if (v < 0)
        v = v + $signed({2'b00, `FMVP_OCTAVE});
    return v[7:0];
  endfunction

  function automatic logic [2:0] clip3(input logic [7:0] v, input logic [2:0] m);
    return (v > {5'h00, m}) ? m : v[2:0];
  endfunction

  logic [8:0] shifted;
  logic [7:0] noteIn;
  assign noteIn  = {1'b0, writedata[6:0]};
  assign shifted = {1'b0, noteIn} + {st_r.xpose[7], st_r.xpose};

  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.keyOn      = st_r.keyOn;
    st_nxt.attack     = 1'b0;
    st_nxt.slide      = 1'b0;
    st_nxt.lfoRestart = 1'b0;
    unique case (st_r.bus)
      fmvp_pkg::ST_IDLE:
      begin
        if (req)
        begin
          st_nxt.bus   = fmvp_pkg::ST_ACK;
          st_nxt.rdata = 32'h0000_0000;
        end
        if (read)
        begin
          unique case (wordAddr)
            `FMVP_A_INST:  st_nxt.rdata = {13'h0000, st_r.lfoOff, st_r.vibSrc, st_r.single,
                                          st_r.bend, 3'h0, st_r.glide};
            `FMVP_A_VOICE: st_nxt.rdata = {5'h00, st_r.role, st_r.opOn, st_r.fb, st_r.alg,
                                          st_r.pitch_mod_sensitivity, st_r.amplitude_mod_sensitivity, st_r.xpose};
            `FMVP_A_CTRL:  st_nxt.rdata = {31'h0000_0000, st_r.follow};
            `FMVP_A_STAT:  st_nxt.rdata = {20'h0_0000, st_r.heldCnt, 1'b0, st_r.keyOn,
                                          st_r.note};
            `FMVP_A_MOD:   st_nxt.rdata = {1'b0, st_r.pmdAct, 1'b0, st_r.amdAct,
                                          st_r.rateAct, 6'h00, st_r.waveAct};
            `FMVP_A_SHIFT: st_nxt.rdata = {20'h0_0000, st_r.lfoLoad, st_r.lfoSync,
                                          st_r.wave, st_r.rate};
            default:       st_nxt.rdata = `FMVP_DEAD;
          endcase
        end
        if (write)
        begin
          unique case (wordAddr)
            `FMVP_A_INST:
            begin
              unique case (writedata[15:8])
                `FMVP_I_GLIDE:  st_nxt.glideSv  = writedata[6:0];
                `FMVP_I_BEND:   st_nxt.bendSv   = (writedata[3:0] > `FMVP_BEND_MAX) ?
                                                  `FMVP_BEND_MAX : writedata[3:0];
                `FMVP_I_PLAY:   st_nxt.singleSv = writedata[0];
                `FMVP_I_VIBSRC: st_nxt.vibSrcSv = clip3(writedata[7:0], `FMVP_VIB_MAX);
                `FMVP_I_LFOENA: st_nxt.lfoOff   = writedata[0];
                default: ;
              endcase
              if (writedata[15:8] != `FMVP_I_LFOENA)
              begin
                st_nxt.glide  = (writedata[15:8] == `FMVP_I_GLIDE) ? writedata[6:0] : st_r.glide;
                st_nxt.bend   = st_nxt.bendSv;
                st_nxt.single = st_nxt.singleSv;
                st_nxt.vibSrc = st_nxt.vibSrcSv;
              end
            end
            `FMVP_A_VOICE:
            begin
              unique case (writedata[15:8])
                `FMVP_V_XPOSE: st_nxt.xpose = writedata[7:0];
                `FMVP_V_ALGFB:
                begin
                  st_nxt.alg = writedata[2:0];
                  st_nxt.fb  = writedata[5:3];
                end
                `FMVP_V_ROLE:  st_nxt.role = writedata[3:0];
                `FMVP_V_OPEN:  st_nxt.opOn = writedata[`FMVP_OPEN_LSB +: 4];
                `FMVP_V_SENS:
                begin
                  st_nxt.amplitude_mod_sensitivity = writedata[1:0];
                  st_nxt.pitch_mod_sensitivity = writedata[4:2];
                end
                `FMVP_V_WAVE:
                begin
                  st_nxt.wave    = writedata[1:0];
                  st_nxt.lfoSync = writedata[2];
                  st_nxt.lfoLoad = writedata[3];
                end
                `FMVP_V_RATE:  st_nxt.rate = writedata[7:0];
                `FMVP_V_AMD:   st_nxt.amplitude_mod_depth  = writedata[6:0];
                `FMVP_V_PMD:   st_nxt.pitch_mod_depth  = writedata[6:0];
                default: ;
              endcase
            end
            `FMVP_A_CTRL:
            begin
              st_nxt.follow = writedata[0];
              // Bit 1 is a voice-select strobe.
              if (writedata[1])
              begin
                if (st_r.follow)
                begin
                  st_nxt.glide  = st_r.glideSv;
                  st_nxt.bend   = st_r.bendSv;
                  st_nxt.single = st_r.singleSv;
                  st_nxt.vibSrc = st_r.vibSrcSv;
                end
                if (st_r.lfoLoad)
                begin
                  st_nxt.waveAct = st_r.wave;
                  st_nxt.rateAct = st_r.rate;
                  st_nxt.amdAct  = st_r.amplitude_mod_depth;
                  st_nxt.pmdAct  = st_r.pitch_mod_depth;
                end
              end
            end
            `FMVP_A_NOTE:
            begin
              if (writedata[8])
              begin
                // Note-on: pushes the note onto the held list.
                st_nxt.held0   = foldNote(shifted);
                st_nxt.held1   = st_r.held0;
                st_nxt.held2   = st_r.held1;
                st_nxt.heldCnt = (st_r.heldCnt == 2'd3) ? 2'd3 : st_r.heldCnt + 2'd1;
                st_nxt.note    = foldNote(shifted);
                st_nxt.keyOn   = 1'b1;
                st_nxt.attack  = !(st_r.single && st_r.keyOn);
                st_nxt.slide   = (st_r.glide != 7'h00) &&
                                 (!st_r.single || st_r.keyOn);
                st_nxt.lfoRestart = st_r.lfoSync;
              end
              else if (st_r.heldCnt != 2'd0 && foldNote(shifted) == st_r.held0)
              begin
                // In single mode with more than one note held, release of the newest note returns to the prior held one; otherwise it clears keyOn.
                st_nxt.held0   = st_r.held1;
                st_nxt.held1   = st_r.held2;
                st_nxt.held2   = 8'h00;
                st_nxt.heldCnt = st_r.heldCnt - 2'd1;
                if (st_r.single && st_r.heldCnt > 2'd1)
                begin
                  st_nxt.note = st_r.held1;
                  st_nxt.slide = (st_r.glide != 7'h00);
                end
                else
                  st_nxt.keyOn = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      fmvp_pkg::ST_ACK: st_nxt.bus = fmvp_pkg::ST_IDLE;
      default:          st_nxt.bus = fmvp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // One wait cycle: a request is answered on the second edge.
  assign waitrequest = req && (st_r.bus == fmvp_pkg::ST_IDLE);
  assign readdata    = st_r.rdata;
  assign playNote    = st_r.note;
  assign keyOn       = st_r.keyOn;
  assign attackStart = st_r.attack;
  assign glideActive = st_r.slide;
  assign lfoRestart  = st_r.lfoRestart;
  assign opEnable    = st_r.opOn;
  assign ampModOn    = !st_r.lfoOff && st_r.amdAct != 7'h00 && st_r.amplitude_mod_sensitivity != 2'd0;
  assign pitchModOn  = !st_r.lfoOff && st_r.pmdAct != 7'h00 && st_r.pitch_mod_sensitivity != 3'd0;

  property p_attack;
    @(posedge mclk) disable iff (!rst_n)
    (st_r.bus == fmvp_pkg::ST_IDLE && write && wordAddr == `FMVP_A_NOTE && writedata[8]
     && st_r.single && st_r.keyOn) |=> !attackStart;
  endproperty
  a_attack: assert property (p_attack) else $error("legato attack not skipped");
  property p_chord;
    @(posedge mclk) disable iff (!rst_n)
    (st_r.bus == fmvp_pkg::ST_IDLE && write && wordAddr == `FMVP_A_NOTE && writedata[8]
     && !st_r.single) |=> attackStart;
  endproperty
  a_chord: assert property (p_chord) else $error("chord attack missing");
  property p_noglide;
    @(posedge mclk) disable iff (!rst_n) (st_r.glide == 7'h00 && $stable(st_r.glide)) |=>
      !glideActive;
  endproperty
  a_noglide: assert property (p_noglide) else $error("glide while off");
  property p_amod;
    @(posedge mclk) disable iff (!rst_n) (st_r.amplitude_mod_sensitivity == 2'd0 || st_r.amdAct == 7'h00) |-> !ampModOn;
  endproperty
  a_amod: assert property (p_amod) else $error("amplitude mod not suppressed");
  property p_lfoff;
    @(posedge mclk) disable iff (!rst_n) st_r.lfoOff |-> !(ampModOn || pitchModOn);
  endproperty
  a_lfoff: assert property (p_lfoff) else $error("excluded instrument modulated");
  property p_bend;
    @(posedge mclk) disable iff (!rst_n) st_r.bend <= `FMVP_BEND_MAX;
  endproperty
  a_bend: assert property (p_bend) else $error("bend span above limit");
  property p_range;
    @(posedge mclk) disable iff (!rst_n) keyOn |-> playNote <= `FMVP_NOTE_TOP;
  endproperty
  a_range: assert property (p_range) else $error("note out of range");
  sequence s_ack;
    ##1 !waitrequest;
  endsequence
  property p_ack;
    @(posedge mclk) disable iff (!rst_n) (req && waitrequest) |-> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_sync;
    @(posedge mclk) disable iff (!rst_n) lfoRestart |-> $past(st_r.lfoSync) && attackStart || keyOn;
  endproperty
  a_sync: assert property (p_sync) else $error("restart without key-on");

  // Strobes as the decoder takes them: only the first cycle of a request acts.
  logic       takeWr;
  logic       noteOffHit;
  logic [7:0] offset;
  assign takeWr     = write && (st_r.bus == fmvp_pkg::ST_IDLE);
  assign offset     = writedata[15:8];
  assign noteOffHit = takeWr && wordAddr == `FMVP_A_NOTE && !writedata[8] &&
                      st_r.heldCnt != 2'd0 && foldNote(shifted) == st_r.held0;
  sequence s_noteOn;
    takeWr && wordAddr == `FMVP_A_NOTE && writedata[8];
  endsequence
  sequence s_select;
    takeWr && wordAddr == `FMVP_A_CTRL && writedata[1];
  endsequence
  property p_slideChord;
    @(posedge mclk) disable iff (!rst_n)
    (s_noteOn ##0 (!st_r.single && st_r.glide != 7'h00)) |=> glideActive;
  endproperty
  a_slideChord: assert property (p_slideChord) else $error("chord note without slide");
  property p_slideFirst;
    @(posedge mclk) disable iff (!rst_n)
    (s_noteOn ##0 (st_r.single && !st_r.keyOn)) |=> !glideActive;
  endproperty
  a_slideFirst: assert property (p_slideFirst) else $error("detached note slid");
  property p_slideLegato;
    @(posedge mclk) disable iff (!rst_n)
    (s_noteOn ##0 (st_r.single && st_r.keyOn && st_r.glide != 7'h00)) |=> glideActive;
  endproperty
  a_slideLegato: assert property (p_slideLegato) else $error("legato slide missing");
  property p_push;
    @(posedge mclk) disable iff (!rst_n)
    s_noteOn |=> keyOn && st_r.held1 == $past(st_r.held0);
  endproperty
  a_push: assert property (p_push) else $error("held note list not pushed");
  property p_return;
    @(posedge mclk) disable iff (!rst_n)
    (noteOffHit && st_r.single && st_r.heldCnt > 2'd1) |=> playNote == $past(st_r.held1);
  endproperty
  a_return: assert property (p_return) else $error("no return to held note");
  property p_playSel;
    @(posedge mclk) disable iff (!rst_n)
    (takeWr && wordAddr == `FMVP_A_INST && offset == `FMVP_I_PLAY) |=>
      st_r.single == $past(writedata[0]);
  endproperty
  a_playSel: assert property (p_playSel) else $error("play mode not taken");
  property p_glideSet;
    @(posedge mclk) disable iff (!rst_n)
    (takeWr && wordAddr == `FMVP_A_INST && offset == `FMVP_I_GLIDE) |=>
      st_r.glide == $past(writedata[6:0]);
  endproperty
  a_glideSet: assert property (p_glideSet) else $error("glide time not taken");
  property p_vib;
    @(posedge mclk) disable iff (!rst_n) st_r.vibSrc <= `FMVP_VIB_MAX;
  endproperty
  a_vib: assert property (p_vib) else $error("vibrato source code above limit");
  property p_algFb;
    @(posedge mclk) disable iff (!rst_n)
    (takeWr && wordAddr == `FMVP_A_VOICE && offset == `FMVP_V_ALGFB) |=>
      st_r.alg == $past(writedata[2:0]) && st_r.fb == $past(writedata[5:3]);
  endproperty
  a_algFb: assert property (p_algFb) else $error("routing or feedback not taken");
  property p_opEn;
    @(posedge mclk) disable iff (!rst_n)
    (takeWr && wordAddr == `FMVP_A_VOICE && offset == `FMVP_V_OPEN) |=>
      opEnable == $past(writedata[`FMVP_OPEN_LSB +: 4]);
  endproperty
  a_opEn: assert property (p_opEn) else $error("operator enables not taken");
  property p_sens;
    @(posedge mclk) disable iff (!rst_n)
    (takeWr && wordAddr == `FMVP_A_VOICE && offset == `FMVP_V_SENS) |=>
      st_r.amplitude_mod_sensitivity == $past(writedata[1:0]) && st_r.pitch_mod_sensitivity == $past(writedata[4:2]);
  endproperty
  a_sens: assert property (p_sens) else $error("sensitivities not taken");
  property p_keepLfo;
    @(posedge mclk) disable iff (!rst_n)
    (s_select ##0 !st_r.lfoLoad) |=> $stable(st_r.waveAct) && $stable(st_r.rateAct) &&
      $stable(st_r.amdAct) && $stable(st_r.pmdAct);
  endproperty
  a_keepLfo: assert property (p_keepLfo) else $error("oscillator replaced without load");
  property p_loadLfo;
    @(posedge mclk) disable iff (!rst_n)
    (s_select ##0 st_r.lfoLoad) |=> st_r.rateAct == $past(st_r.rate) &&
      st_r.amdAct == $past(st_r.amplitude_mod_depth) && st_r.pmdAct == $past(st_r.pitch_mod_depth);
  endproperty
  a_loadLfo: assert property (p_loadLfo) else $error("oscillator not loaded");
  property p_keepFn;
    @(posedge mclk) disable iff (!rst_n)
    (s_select ##0 !st_r.follow) |=> $stable(st_r.glide) && $stable(st_r.bend) &&
      $stable(st_r.single) && $stable(st_r.vibSrc);
  endproperty
  a_keepFn: assert property (p_keepFn) else $error("function settings changed on select");
  property p_restart;
    @(posedge mclk) disable iff (!rst_n)
    (s_noteOn ##0 st_r.lfoSync) |=> lfoRestart;
  endproperty
  a_restart: assert property (p_restart) else $error("key-sync restart missing");
  property p_freeRun;
    @(posedge mclk) disable iff (!rst_n)
    (s_noteOn ##0 !st_r.lfoSync) |=> !lfoRestart;
  endproperty
  a_freeRun: assert property (p_freeRun) else $error("free-running oscillator restarted");
  property p_pmod;
    @(posedge mclk) disable iff (!rst_n) (st_r.pitch_mod_sensitivity == 3'd0 || st_r.pmdAct == 7'h00) |-> !pitchModOn;
  endproperty
  a_pmod: assert property (p_pmod) else $error("pitch mod not suppressed");
endmodule

// file: test/fmvp_host_model.sv
module fmvp_host_model
(
  input  wire logic        mclk,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic             rdValid,
  output logic      [31:0] rdData
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
  end

  // Each parameter goes over as one offset and value word; role flags are
  // written by the host to suit the pattern, the device never derives them.
  task automatic access(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    @(posedge mclk iff waitrequest === 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    // Stale data is inverted so a slave that samples late cannot pass.
    writedata <= ~d;
  endtask

  always_ff @(posedge mclk)
  begin
    rdValid <= read && (waitrequest === 1'b0);
    rdData <= readdata;
  end
endmodule

// file: test/fm_voice_parameter_control_bench.sv
`include "fmvp_cfg.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module fm_voice_parameter_control_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk;
  logic        rst_n;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  playNote;
  logic        keyOn;
  logic        attackStart;
  logic        glideActive;
  logic        lfoRestart;
  logic [3:0]  opEnable;
  logic        ampModOn;
  logic        pitchModOn;
  logic        rdValid;
  logic [31:0] rdData;
  logic [31:0] expQ[$];
  logic [31:0] expRd;
  int          n_mismatch;
  int          comparisons;
  int          nAtk;
  int          nGl;
  int          nRst;
  int          seed;
  logic [6:0]  g;
  logic [3:0]  b;

  fmvp_voice_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .playNote(playNote), .keyOn(keyOn), .attackStart(attackStart),
    .glideActive(glideActive), .lfoRestart(lfoRestart), .opEnable(opEnable),
    .ampModOn(ampModOn), .pitchModOn(pitchModOn));
  fmvp_host_model u_host (.mclk(mclk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rdValid(rdValid), .rdData(rdData));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic wr(input logic [3:0] w, input logic [31:0] d);
    u_host.access(1'b0, {w, 2'b00}, d);
  endtask
  task automatic rd(input logic [3:0] w, input logic [31:0] e);
    expQ.push_back(e);
    u_host.access(1'b1, {w, 2'b00}, 32'h0000_0000);
  endtask
  task automatic inst(input logic [7:0] o, input logic [7:0] v);
    wr(`FMVP_A_INST, {16'h0000, o, v});
  endtask
  task automatic voice(input logic [7:0] o, input logic [7:0] v);
    wr(`FMVP_A_VOICE, {16'h0000, o, v});
  endtask
  task automatic note(input logic [6:0] n, input logic on);
    wr(`FMVP_A_NOTE, {23'h00_0000, on, 1'b0, n});
    repeat (4) @(posedge mclk);
  endtask
  task automatic clr();
    nAtk = 0;
    nGl = 0;
    nRst = 0;
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Read results are matched oldest first against what the driver noted.
  always @(posedge mclk)
  begin
    nAtk += (attackStart === 1'b1);
    nGl += (glideActive === 1'b1);
    nRst += (lfoRestart === 1'b1);
    if (rdValid === 1'b1)
    begin
      // Popped once up front so a mismatch report cannot consume a second note.
      expRd = expQ.pop_front();
      `CHK(rdData, expRd)
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    seed = 65;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    `CHK({keyOn, opEnable, ampModOn}, 6'h00)
    rd(4'h7, `FMVP_DEAD);
    wr(4'h7, 32'h0000_FFFF);
    for (int i = 0; i < 5; i++)
    begin
      g = (i == 4) ? `FMVP_GLIDE_MAX : 7'($random(seed));
      b = (i == 4) ? `FMVP_BEND_MAX : 4'($unsigned($random(seed)) % 13);
      inst(`FMVP_I_GLIDE, {1'b0, g});
      inst(`FMVP_I_BEND, {4'h0, b});
      inst(`FMVP_I_VIBSRC, 8'(i));
      inst(`FMVP_I_PLAY, 8'(i % 2));
      inst(`FMVP_I_LFOENA, 8'(i / 4));
      rd(`FMVP_A_INST, {13'h0, i == 4, 3'(i), i[0], b, 3'h0, g});
    end
    inst(`FMVP_I_PLAY, 8'h00);
    inst(`FMVP_I_GLIDE, 8'h05);
    clr();
    note(7'h3C, 1'b1);
    note(7'h3E, 1'b1);
    `CHK({nAtk, nGl}, {32'd2, 32'd2})
    note(7'h3E, 1'b0);
    note(7'h3C, 1'b0);
    inst(`FMVP_I_PLAY, 8'h01);
    clr();
    note(7'h3C, 1'b1);
    note(7'h40, 1'b1);
    note(7'h43, 1'b1);
    `CHK({nAtk, nGl, playNote}, {32'd1, 32'd2, 8'h43})
    rd(`FMVP_A_STAT, {20'h0_0000, 2'h3, 1'b0, 1'b1, 8'h43});
    note(7'h43, 1'b0);
    `CHK(playNote, 8'h40)
    note(7'h40, 1'b0);
    `CHK({keyOn, playNote}, 9'h13C)
    note(7'h3C, 1'b0);
    `CHK(keyOn, 1'b0)
    inst(`FMVP_I_PLAY, 8'h00);
    inst(`FMVP_I_GLIDE, 8'h00);
    voice(`FMVP_V_XPOSE, `FMVP_OCTAVE);
    voice(`FMVP_V_OPEN, 8'h58);
    voice(`FMVP_V_ALGFB, 8'h3F);
    voice(`FMVP_V_ROLE, 8'h08);
    clr();
    note(7'h3C, 1'b1);
    `CHK({playNote, opEnable, 32'(nGl)}, {8'h48, 4'hB, 32'd0})
    note(7'h3C, 1'b0);
    note(7'h7F, 1'b1);
    `CHK(playNote, `FMVP_NOTE_TOP)
    note(7'h7F, 1'b0);
    voice(`FMVP_V_XPOSE, 8'h80);
    note(7'h0A, 1'b1);
    `CHK(playNote, 8'h02)
    note(7'h0A, 1'b0);
    voice(`FMVP_V_AMD, 8'h40);
    voice(`FMVP_V_PMD, 8'h00);
    voice(`FMVP_V_SENS, 8'h0E);
    voice(`FMVP_V_WAVE, 8'h0E);
    voice(`FMVP_V_RATE, 8'hFF);
    inst(`FMVP_I_LFOENA, 8'h00);
    wr(`FMVP_A_CTRL, 32'h0000_0002);
    rd(`FMVP_A_VOICE, {5'h00, 4'h8, 4'hB, 3'h7, 3'h7, 3'h3, 2'h2, 8'h80});
    rd(`FMVP_A_MOD, {1'b0, 7'h00, 1'b0, 7'h40, 8'hFF, 6'h00, 2'h2});
    rd(`FMVP_A_SHIFT, {20'h0_0000, 1'b1, 1'b1, 2'h2, 8'hFF});
    clr();
    note(7'h30, 1'b1);
    `CHK({ampModOn, pitchModOn, 32'(nRst)}, {2'b10, 32'd1})
    note(7'h30, 1'b0);
    voice(`FMVP_V_AMD, 8'h00);
    voice(`FMVP_V_WAVE, 8'h02);
    wr(`FMVP_A_CTRL, 32'h0000_0002);
    `CHK({ampModOn, pitchModOn}, 2'b10)
    voice(`FMVP_V_PMD, 8'h20);
    voice(`FMVP_V_WAVE, 8'h0A);
    wr(`FMVP_A_CTRL, 32'h0000_0002);
    clr();
    note(7'h30, 1'b1);
    `CHK({ampModOn, pitchModOn, 32'(nRst)}, {2'b01, 32'd0})
    inst(`FMVP_I_LFOENA, 8'h01);
    note(7'h30, 1'b0);
    `CHK({ampModOn, pitchModOn}, 2'b00)
    repeat (4) @(posedge mclk);
    summarize();
  end
endmodule
